// ---- shared/mem_clk_consts.vh ----
// Constants for the memory layout and clock ratio configuration registers
`ifndef MEM_CLK_CONSTS_VH
`define MEM_CLK_CONSTS_VH

// Register indices on the word-only access port
`define IDX_MEM_LAYOUT       1'h0
`define IDX_CLK_RATIO        1'h1

// Memory layout word: field positions
`define LAY_SIZE_LSB         0
`define LAY_SIZE_MSB         2
`define LAY_BIT3             3
`define LAY_REFRESH_LSB      16
`define LAY_REFRESH_MSB      31

// Clock ratio word: field positions
`define CLK_CORE_RATIO_LSB   0
`define CLK_CORE_RATIO_MSB   2
`define CLK_MEM_RATIO        4
`define CLK_CORE_OFF         8
`define CLK_CORE_BYP         9
`define CLK_MEM_OFF          12
`define CLK_MEM_BYP          13

// Bits that hold a field; all others read as zero
`define LAY_MASK             32'hffff_000f
`define CLK_MASK             32'h0000_3317

// Reset values: refresh 1000, rank code 4, ratios 0, PLLs off and bypassed
`define LAY_RESET            32'h03e8_0004
`define CLK_RESET            32'h0000_3300

// Rank size codes
`define RANK_512K            3'h1
`define RANK_1M              3'h2
`define RANK_2M              3'h3
`define RANK_4M              3'h4
`define RANK_8M              3'h5
`define RANK_16M             3'h6

// Rank sizes in kilobytes
`define KB_512K              15'h0200
`define KB_1M                15'h0400
`define KB_2M                15'h0800
`define KB_4M                15'h1000
`define KB_8M                15'h2000
`define KB_16M               15'h4000

// Core ratio codes; higher codes are reserved
`define CORE_1_1             3'h0
`define CORE_2_1             3'h1
`define CORE_3_2             3'h2
`define CORE_4_3             3'h3
`define CORE_5_4             3'h4

`endif

// ---- core/cfg_word_holder.v ----
// One configuration word, loaded only while the load enable is high
`timescale 1ns/10ps
`include "mem_clk_consts.vh"

module cfg_word_holder #(
	parameter [31:0] RESET_VAL = 32'h0000_0000,
	parameter [31:0] FIELD_MASK = 32'hffff_ffff
) (
	input  wire        sys_clk_in,
	input  wire        rst_n_in,
	input  wire        load_in,
	input  wire [31:0] data_in,
	output wire [31:0] word_out
);

	reg [31:0] word_q;
	reg [31:0] word_d;

	// Next value: masked load, otherwise hold
	always @* begin
		word_d = word_q;
		if (load_in) begin
			word_d = data_in & FIELD_MASK;
		end
	end

	// Word storage with its reset value
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			word_q <= RESET_VAL;
		end else begin
			word_q <= word_d;
		end
	end

	assign word_out = word_q;

endmodule // cfg_word_holder

// ---- core/clk_path_decode.v ----
// Decodes rank size, PLL ratios and clock path selection from the two words
`timescale 1ns/10ps
`include "mem_clk_consts.vh"

module clk_path_decode (
	input  wire [31:0] layout_in,
	input  wire [31:0] ratio_in,
	output reg  [14:0] rank_kb_out,
	output reg         rank_ok_out,
	output reg  [2:0]  core_mult_out,
	output reg  [2:0]  core_div_out,
	output reg         core_ok_out,
	output wire [1:0]  mem_mult_out,
	output wire [3:0]  eff_num_out,
	output wire [2:0]  eff_den_out,
	output wire        path_bad_out
);

	wire [2:0] size_code;
	wire [2:0] core_code;
	wire       core_off;
	wire       core_byp;
	wire       mem_off;
	wire       mem_byp;
	wire [1:0] mem_fac;
	wire [2:0] cmul;
	wire [2:0] cdiv;
	wire [5:0] prod;

	assign size_code = layout_in[`LAY_SIZE_MSB:`LAY_SIZE_LSB];
	assign core_code = ratio_in[`CLK_CORE_RATIO_MSB:`CLK_CORE_RATIO_LSB];
	assign core_off  = ratio_in[`CLK_CORE_OFF];
	assign core_byp  = ratio_in[`CLK_CORE_BYP];
	assign mem_off   = ratio_in[`CLK_MEM_OFF];
	assign mem_byp   = ratio_in[`CLK_MEM_BYP];

	always @* begin
		rank_ok_out = 1'b1;
		case (size_code)
			`RANK_512K: rank_kb_out = `KB_512K;
			`RANK_1M:   rank_kb_out = `KB_1M;
			`RANK_2M:   rank_kb_out = `KB_2M;
			`RANK_4M:   rank_kb_out = `KB_4M;
			`RANK_8M:   rank_kb_out = `KB_8M;
			`RANK_16M:  rank_kb_out = `KB_16M;
			default: begin
				rank_kb_out = 15'h0000;
				rank_ok_out = 1'b0;
			end
		endcase
	end

	always @* begin
		core_ok_out = 1'b1;
		case (core_code)
			`CORE_1_1: begin
				core_mult_out = 3'h1;
				core_div_out  = 3'h1;
			end
			`CORE_2_1: begin
				core_mult_out = 3'h2;
				core_div_out  = 3'h1;
			end
			`CORE_3_2: begin
				core_mult_out = 3'h3;
				core_div_out  = 3'h2;
			end
			`CORE_4_3: begin
				core_mult_out = 3'h4;
				core_div_out  = 3'h3;
			end
			`CORE_5_4: begin
				core_mult_out = 3'h5;
				core_div_out  = 3'h4;
			end
			default: begin
				core_mult_out = 3'h1;
				core_div_out  = 3'h1;
				core_ok_out   = 1'b0;
			end
		endcase
	end

	// memory ratio; bypass takes the external clock
	assign mem_mult_out = ratio_in[`CLK_MEM_RATIO] ? 2'h3 : 2'h2;
	assign mem_fac      = mem_byp ? 2'h1 : mem_mult_out;
	// core bypass uses the memory clock; both bypassed gives 1:1
	assign cmul = core_byp ? 3'h1 : core_mult_out;
	assign cdiv = core_byp ? 3'h1 : core_div_out;
	assign prod = {4'h0, mem_fac} * {3'h0, cmul};
	assign eff_num_out = prod[3:0];
	assign eff_den_out = cdiv;
	// selecting a disabled PLL output is flagged
	assign path_bad_out = (core_off & ~core_byp) | (mem_off & ~mem_byp);

endmodule // clk_path_decode

// ---- core/mem_clk_cfg_regs.v ----
// Memory layout and clock ratio configuration registers with PLL controls
//
// Functional notes
// - Boot loader loads both words while the memory interface stays in reset.
// - After memory interface reset release, words freeze; reads work, writes ignored.
// - Sixteen-bit refresh interval in memory clock cycles, default 1000.
// - Rank code 1..6 means 512KB..16MB; 0 and 7 reserved; default 4MB.
// - Core ratio codes 0..4 give 1:1,2:1,3:2,4:3,5:4; default 0.
// - Core PLL reference is the memory clock; its output sets core rate.
// - Memory ratio bit selects twice or three times the external clock.
// - Core PLL off bit, reset one; zero turns the PLL on.
// - Core bypass, default one, clocks core from memory clock.
// - Both bypasses set: core runs at the external clock rate.
// - Memory PLL off bit, reset one; zero turns the PLL on.
// - Memory bypass, default one, clocks memory from the external clock.
// - Access moves whole 32-bit words; byte enables are ignored.
`timescale 1ns/10ps
`include "mem_clk_consts.vh"

module mem_clk_cfg_regs (
	input  wire        sys_clk_in,
	input  wire        rst_n_in,
	// Boot loader load port
	input  wire        boot_wr_in,
	input  wire        boot_sel_in,
	input  wire [31:0] boot_data_in,
	input  wire        boot_done_in,
	// Word-only register access port
	input  wire        mmio_rd_in,
	input  wire        mmio_wr_in,
	input  wire        mmio_sel_in,
	input  wire [3:0]  mmio_be_in,
	input  wire [31:0] mmio_wdata_in,
	output wire [31:0] mmio_rdata_out,
	output wire        mmio_rvalid_out,
	output wire        mmio_wr_dropped_out,
	// Memory interface controls
	output wire        mem_if_rst_out,
	output wire        cfg_locked_out,
	output wire [15:0] refresh_interval_out,
	output wire [2:0]  rank_code_out,
	output wire [14:0] rank_kb_out,
	output wire        rank_ok_out,
	// Memory PLL controls
	output wire        mem_pll_off_out,
	output wire        mem_pll_bypass_out,
	output wire [1:0]  mem_pll_mult_out,
	// Core PLL controls
	output wire        core_pll_off_out,
	output wire        core_pll_bypass_out,
	output wire [2:0]  core_pll_mult_out,
	output wire [2:0]  core_pll_div_out,
	output wire        core_ratio_ok_out,
	// Core clock versus external clock
	output wire [3:0]  core_eff_num_out,
	output wire [2:0]  core_eff_den_out,
	output wire        clk_path_bad_out
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	// Hold, freeze and read port state
	reg         mem_if_rst_q;
	reg         locked_q;
	reg  [31:0] rdata_q;
	reg  [31:0] rdata_d;
	reg         rvalid_q;
	reg         wr_drop_q;

	// Registered control outputs, one per output port
	reg  [15:0] refresh_q;
	reg  [2:0]  rank_code_q;
	reg  [14:0] rank_kb_q;
	reg         rank_ok_q;
	reg         mem_off_q;
	reg         mem_byp_q;
	reg  [1:0]  mem_mult_q;
	reg         core_off_q;
	reg         core_byp_q;
	reg  [2:0]  core_mult_q;
	reg  [2:0]  core_div_q;
	reg         core_ok_q;
	reg  [3:0]  eff_num_q;
	reg  [2:0]  eff_den_q;
	reg         path_bad_q;

	// Load strobes, stored words and decoded fields
	wire        load_open;
	wire        load_lay;
	wire        load_clk;
	wire [31:0] lay_word;
	wire [31:0] clk_word;
	wire [14:0] dec_rank_kb;
	wire        dec_rank_ok;
	wire [2:0]  dec_core_mult;
	wire [2:0]  dec_core_div;
	wire        dec_core_ok;
	wire [1:0]  dec_mem_mult;
	wire [3:0]  dec_eff_num;
	wire [2:0]  dec_eff_den;
	wire        dec_path_bad;

	////////////////////////////////////////////////////////////////////////
	// Load window

	// loads only while the memory interface is held
	assign load_open = mem_if_rst_q & ~locked_q;
	// MMIO writes never reach the words
	assign load_lay  = load_open & boot_wr_in & (boot_sel_in == `IDX_MEM_LAYOUT);
	assign load_clk  = load_open & boot_wr_in & (boot_sel_in == `IDX_CLK_RATIO);

	// A done flag that arrives with a load strobe waits until the strobe drops, so the
	// last word is stored before the freeze; only a new reset reopens it
	// hold memory interface in reset until boot is done
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mem_if_rst_q <= 1'b1;
			locked_q     <= 1'b0;
		end else if (load_open && boot_done_in && !boot_wr_in) begin
			mem_if_rst_q <= 1'b0;
			// words frozen from here until reset
			locked_q     <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Storage

	// Each word keeps only its field bits, so software never sees stale
	// values in unused positions whatever the loader sends
	// refresh default 1000; rank default 4MB; unused bits zero
	cfg_word_holder #(
		.RESET_VAL  (`LAY_RESET),
		.FIELD_MASK (`LAY_MASK)
	) u_layout (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.load_in    (load_lay),
		.data_in    (boot_data_in),
		.word_out   (lay_word)
	);

	// The clock word starts with both PLLs powered down and bypassed
	// PLLs off and bypassed at reset; ratio code 0
	cfg_word_holder #(
		.RESET_VAL  (`CLK_RESET),
		.FIELD_MASK (`CLK_MASK)
	) u_clk_ratio (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.load_in    (load_clk),
		.data_in    (boot_data_in),
		.word_out   (clk_word)
	);

	////////////////////////////////////////////////////////////////////////
	// Decode

	// Field decode shared by the clock and memory controls
	// Purely combinational; every result is registered below before it
	// leaves the block, so output timing does not depend on decode depth
	clk_path_decode u_decode (
		.layout_in     (lay_word),
		.ratio_in      (clk_word),
		.rank_kb_out   (dec_rank_kb),
		.rank_ok_out   (dec_rank_ok),
		.core_mult_out (dec_core_mult),
		.core_div_out  (dec_core_div),
		.core_ok_out   (dec_core_ok),
		.mem_mult_out  (dec_mem_mult),
		.eff_num_out   (dec_eff_num),
		.eff_den_out   (dec_eff_den),
		.path_bad_out  (dec_path_bad)
	);

	////////////////////////////////////////////////////////////////////////
	// Register read port

	// Byte enables and write data are never read: every access is a full
	// word, and a write cannot reach the stored words in any state
	// Read data holds its last value between reads
	// whole word returned, byte enables ignored
	always @* begin
		rdata_d = rdata_q;
		if (mmio_rd_in) begin
			if (mmio_sel_in == `IDX_MEM_LAYOUT) begin
				rdata_d = lay_word;
			end else begin
				rdata_d = clk_word;
			end
		end
	end

	// Read data and strobes
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_q   <= 32'h0000_0000;
			rvalid_q  <= 1'b0;
			wr_drop_q <= 1'b0;
		end else begin
			rdata_q   <= rdata_d;
			rvalid_q  <= mmio_rd_in;
			// writes discarded, reported by a pulse
			wr_drop_q <= mmio_wr_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered controls

	// Memory side: refresh count, rank size and memory PLL
	// Outputs follow the stored word one cycle late; once frozen they stay put
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			refresh_q   <= 16'h0000;
			rank_code_q <= 3'h0;
			rank_kb_q   <= 15'h0000;
			rank_ok_q   <= 1'b0;
			mem_off_q   <= 1'b1;
			mem_byp_q   <= 1'b1;
			mem_mult_q  <= 2'h2;
		end else begin
			// interval counted in memory clock cycles
			refresh_q   <= lay_word[`LAY_REFRESH_MSB:`LAY_REFRESH_LSB];
			rank_code_q <= lay_word[`LAY_SIZE_MSB:`LAY_SIZE_LSB];
			rank_kb_q   <= dec_rank_kb;
			rank_ok_q   <= dec_rank_ok & ~lay_word[`LAY_BIT3];
			mem_off_q   <= clk_word[`CLK_MEM_OFF];
			mem_byp_q   <= clk_word[`CLK_MEM_BYP];
			mem_mult_q  <= dec_mem_mult;
		end
	end

	// Core side: core PLL fed from the memory clock
	// Reserved ratio codes fall back to 1:1 and clear the ratio good flag
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			core_off_q  <= 1'b1;
			core_byp_q  <= 1'b1;
			core_mult_q <= 3'h1;
			core_div_q  <= 3'h1;
			core_ok_q   <= 1'b1;
			eff_num_q   <= 4'h1;
			eff_den_q   <= 3'h1;
			path_bad_q  <= 1'b0;
		end else begin
			core_off_q  <= clk_word[`CLK_CORE_OFF];
			core_byp_q  <= clk_word[`CLK_CORE_BYP];
			// core PLL ratio on the memory clock
			core_mult_q <= dec_core_mult;
			core_div_q  <= dec_core_div;
			core_ok_q   <= dec_core_ok;
			// core rate relative to the external clock
			eff_num_q   <= dec_eff_num;
			eff_den_q   <= dec_eff_den;
			path_bad_q  <= dec_path_bad;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Register access answers
	assign mmio_rdata_out       = rdata_q;
	assign mmio_rvalid_out      = rvalid_q;
	assign mmio_wr_dropped_out  = wr_drop_q;

	// Hold and freeze state
	assign mem_if_rst_out       = mem_if_rst_q;
	assign cfg_locked_out       = locked_q;

	// Memory interface and memory PLL controls
	assign refresh_interval_out = refresh_q;
	assign rank_code_out        = rank_code_q;
	assign rank_kb_out          = rank_kb_q;
	assign rank_ok_out          = rank_ok_q;
	assign mem_pll_off_out      = mem_off_q;
	assign mem_pll_bypass_out   = mem_byp_q;
	assign mem_pll_mult_out     = mem_mult_q;

	// Core PLL controls and core rate
	assign core_pll_off_out     = core_off_q;
	assign core_pll_bypass_out  = core_byp_q;
	assign core_pll_mult_out    = core_mult_q;
	assign core_pll_div_out     = core_div_q;
	assign core_ratio_ok_out    = core_ok_q;
	assign core_eff_num_out     = eff_num_q;
	assign core_eff_den_out     = eff_den_q;
	assign clk_path_bad_out     = path_bad_q;

endmodule // mem_clk_cfg_regs

// ---- verif/mem_clk_cfg_regs_properties.sv ----
// Port checks for the configuration register block
`timescale 1ns/10ps
module mem_clk_cfg_checker (
	input wire        sys_clk_in,
	input wire        rst_n_in,
	input wire        boot_wr_in,
	input wire        boot_sel_in,
	input wire [31:0] boot_data_in,
	input wire        mmio_rd_in,
	input wire        mmio_wr_in,
	input wire [31:0] mmio_rdata_out,
	input wire        mmio_rvalid_out,
	input wire        mmio_wr_dropped_out,
	input wire        mem_if_rst_out,
	input wire        cfg_locked_out,
	input wire [15:0] refresh_interval_out,
	input wire [2:0]  rank_code_out,
	input wire [14:0] rank_kb_out,
	input wire        rank_ok_out,
	input wire        mem_pll_off_out,
	input wire        mem_pll_bypass_out,
	input wire        core_pll_off_out,
	input wire        core_pll_bypass_out,
	input wire [3:0]  core_eff_num_out,
	input wire [2:0]  core_eff_den_out,
	input wire        clk_path_bad_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////////////////////////////////////
	chk_read_answer: assert property (mmio_rd_in |=> mmio_rvalid_out)
		else $error("read not answered");
	chk_write_drop: assert property (mmio_wr_in |=> mmio_wr_dropped_out)
		else $error("write not dropped");
	chk_rdata_hold: assert property (!mmio_rvalid_out |-> $stable(mmio_rdata_out))
		else $error("read data moved");
	chk_lock_pair: assert property (mem_if_rst_out != cfg_locked_out)
		else $error("lock and reset disagree");
	chk_frozen_cfg: assert property (cfg_locked_out && $past(cfg_locked_out) |->
		$stable({refresh_interval_out, rank_code_out, core_pll_off_out, mem_pll_bypass_out}))
		else $error("frozen word changed");
	chk_refresh_load: assert property (boot_wr_in && !boot_sel_in && !cfg_locked_out |->
		##2 refresh_interval_out == $past(boot_data_in[31:16], 2))
		else $error("refresh not loaded");
	chk_rank_size: assert property (rank_ok_out |->
		rank_kb_out == (15'h0200 << (rank_code_out - 3'h1)))
		else $error("rank size wrong");
	chk_direct_clock: assert property (core_pll_bypass_out && mem_pll_bypass_out |->
		core_eff_num_out == 4'h1 && core_eff_den_out == 3'h1)
		else $error("core not at input rate");
	chk_path_flag: assert property (clk_path_bad_out ==
		(core_pll_off_out && !core_pll_bypass_out || mem_pll_off_out && !mem_pll_bypass_out))
		else $error("path flag wrong");
	cov_back_reads: cover property (mmio_rd_in ##1 mmio_rd_in);
	cov_locked_write: cover property (cfg_locked_out && mmio_wr_in);
	cov_bad_path: cover property (clk_path_bad_out);
endmodule // mem_clk_cfg_checker

bind mem_clk_cfg_regs mem_clk_cfg_checker i_chk (.sys_clk_in, .rst_n_in, .boot_wr_in,
	.boot_sel_in, .boot_data_in, .mmio_rd_in, .mmio_wr_in, .mmio_rdata_out, .mmio_rvalid_out,
	.mmio_wr_dropped_out, .mem_if_rst_out, .cfg_locked_out, .refresh_interval_out,
	.rank_code_out, .rank_kb_out, .rank_ok_out, .mem_pll_off_out, .mem_pll_bypass_out,
	.core_pll_off_out, .core_pll_bypass_out, .core_eff_num_out, .core_eff_den_out,
	.clk_path_bad_out);

// ---- verif/boot_loader_model.sv ----
// Boot loader model that fills the two configuration words
`timescale 1ns/10ps
module boot_loader_model (
	input  wire        sys_clk_in,
	output reg         boot_wr_out,
	output reg         boot_sel_out,
	output reg  [31:0] boot_data_out,
	output reg         boot_done_out
);
	reg [31:0] last_w;
	// Idle lines at start
	initial begin
		boot_wr_out = 1'b0;
		boot_sel_out = 1'b0;
		boot_data_out = 32'h5a5a_a5a5;
		boot_done_out = 1'b0;
		last_w = 32'h0;
	end
	////////////////////////////////////////////////////////////////
	// One word, then gap idle cycles; released data shows its inverse
	task load(input sel, input [31:0] d, input clean, input integer gap);
		begin
			last_w = d;
			if (clean && !sel)
				last_w[3] = 1'b0;
			if (clean && sel)
				last_w = last_w | {18'h0, last_w[12], 3'h0, last_w[8], 9'h0};
			boot_wr_out = 1'b1;
			boot_sel_out = sel;
			boot_data_out = last_w;
			@(posedge sys_clk_in);
			#1;
			boot_wr_out = 1'b0;
			boot_data_out = ~last_w;
			repeat (gap) begin
				@(posedge sys_clk_in);
				#1;
			end
		end
	endtask
	task finish(input on);
		boot_done_out = on;
	endtask
endmodule // boot_loader_model

// ---- verif/mem_clk_cfg_regs_tb_top.sv ----
// Self-checking bench for the configuration register block
`timescale 1ns/10ps
`include "mem_clk_consts.vh"
module mem_clk_cfg_regs_tb_top;
	reg         sys_clk_in, rst_n_in, mmio_rd_in, mmio_wr_in, mmio_sel_in;
	reg  [3:0]  mmio_be_in;
	reg  [31:0] mmio_wdata_in, seed, d, ev, lay_e, clk_e;
	wire        boot_wr_in, boot_sel_in, boot_done_in, mmio_rvalid_out, mmio_wr_dropped_out;
	wire [31:0] boot_data_in, mmio_rdata_out;
	wire        mem_if_rst_out, cfg_locked_out, rank_ok_out, mem_pll_off_out;
	wire        mem_pll_bypass_out, core_pll_off_out, core_pll_bypass_out;
	wire        core_ratio_ok_out, clk_path_bad_out;
	wire [15:0] refresh_interval_out;
	wire [2:0]  rank_code_out, core_pll_mult_out, core_pll_div_out, core_eff_den_out;
	wire [14:0] rank_kb_out;
	wire [1:0]  mem_pll_mult_out;
	wire [3:0]  core_eff_num_out;
	integer     err_total, n_tests, i, k;
	reg  [31:0] exp_q[$];
	////////////////////////////////////////////////////////////////
	mem_clk_cfg_regs i_dut (.sys_clk_in, .rst_n_in, .boot_wr_in, .boot_sel_in,
		.boot_data_in, .boot_done_in, .mmio_rd_in, .mmio_wr_in, .mmio_sel_in, .mmio_be_in,
		.mmio_wdata_in, .mmio_rdata_out, .mmio_rvalid_out, .mmio_wr_dropped_out,
		.mem_if_rst_out, .cfg_locked_out, .refresh_interval_out, .rank_code_out, .rank_kb_out,
		.rank_ok_out, .mem_pll_off_out, .mem_pll_bypass_out, .mem_pll_mult_out,
		.core_pll_off_out, .core_pll_bypass_out, .core_pll_mult_out, .core_pll_div_out,
		.core_ratio_ok_out, .core_eff_num_out, .core_eff_den_out, .clk_path_bad_out);
	boot_loader_model i_ldr (.sys_clk_in, .boot_wr_out(boot_wr_in),
		.boot_sel_out(boot_sel_in), .boot_data_out(boot_data_in), .boot_done_out(boot_done_in));
	// 25 MHz clock
	initial sys_clk_in = 1'b0;
	always #20 sys_clk_in = ~sys_clk_in;
	////////////////////////////////////////////////////////////////
	function [31:0] xs(input [31:0] x);
		reg [31:0] y;
		begin
			y = x ^ (x << 13);
			y = y ^ (y >> 17);
			xs = y ^ (y << 5);
		end
	endfunction
	task tick;
		begin
			@(posedge sys_clk_in);
			#1;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("unexpected at %0t: got %h want %h", $time, g, e);
			end
		end
	endtask
	// Read request; the expected word waits in the queue
	task rd(input s, input [31:0] e);
		begin
			mmio_rd_in = 1'b1;
			mmio_sel_in = s;
			exp_q.push_back(e);
			tick;
		end
	endtask
	task rd_stop;
		begin
			mmio_rd_in = 1'b0;
			tick;
		end
	endtask
	task summarize;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, err_total);
			if (err_total == 0 && n_tests > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task check_defaults;
		begin
			chk(refresh_interval_out, 32'd1000);
			chk({rank_ok_out, rank_code_out, rank_kb_out}, {1'b1, 3'h4, 15'h1000});
			chk({core_pll_off_out, core_pll_bypass_out}, 32'h3);
			chk({mem_pll_off_out, mem_pll_bypass_out}, 32'h3);
			chk({mem_pll_mult_out, core_eff_num_out, core_eff_den_out}, 32'h109);
			chk({mem_if_rst_out, cfg_locked_out}, 32'h2);
			rd(1'b0, `LAY_RESET);
			rd(1'b1, `CLK_RESET);
			rd_stop;
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Monitor: each read answer is matched to the oldest note
	always @(negedge sys_clk_in)
		if (mmio_rvalid_out === 1'b1)
			chk(mmio_rdata_out, exp_q.size() ? exp_q.pop_front() : 32'hxxxx_xxxx);
	// Cut a hang short
	initial begin
		#100000;
		chk(32'h1, 32'h0);
		summarize;
	end
	// Main sequence
	initial begin
		err_total = 0;
		n_tests = 0;
		seed = 32'd72;
		rst_n_in = 1'b0;
		mmio_rd_in = 1'b0;
		mmio_wr_in = 1'b0;
		mmio_sel_in = 1'b0;
		mmio_be_in = 4'h0;
		mmio_wdata_in = 32'h0;
		repeat (8) @(posedge sys_clk_in);
		#1;
		rst_n_in = 1'b1;
		tick;
		check_defaults;
		// Every rank code with a random refresh interval
		for (i = 0; i < 8; i = i + 1) begin
			seed = xs(seed);
			d = {seed[31:4], 1'b0, i[2:0]};
			i_ldr.load(1'b0, d, 1'b1, 1);
			tick;
			k = (i > 0 && i < 7);
			ev = {k[0], i[2:0], k ? (15'h0200 << (i - 1)) : 15'h0};
			chk(refresh_interval_out, d[31:16]);
			chk({rank_ok_out, rank_code_out, rank_kb_out}, ev);
			rd(1'b0, d & `LAY_MASK);
			rd_stop;
		end
		i_ldr.load(1'b0, 32'h08a2_000c, 1'b0, 1);
		tick;
		chk(rank_ok_out, 32'h0);
		// Every core ratio code, legal and illegal PLL paths
		for (i = 0; i < 8; i = i + 1) begin
			seed = xs(seed);
			i_ldr.load(1'b1, {seed[31:3], i[2:0]}, i[0], 1);
			tick;
			d = i_ldr.last_w;
			ev = i < 5 ? {i[2:0] + 3'h1, (i == 0) ? 3'h1 : i[2:0], 1'b1} : 32'h12;
			chk({core_pll_mult_out, core_pll_div_out, core_ratio_ok_out}, ev);
			chk(mem_pll_mult_out, d[4] ? 32'h3 : 32'h2);
			chk(clk_path_bad_out, (d[8] & ~d[9]) | (d[12] & ~d[13]));
			chk({core_pll_off_out, core_pll_bypass_out}, {d[8], d[9]});
			chk({mem_pll_off_out, mem_pll_bypass_out}, {d[12], d[13]});
			if (d[9] & d[13])
				chk({core_eff_num_out, core_eff_den_out}, 32'h9);
			chk(core_eff_num_out, (d[13] ? 1 : 2 + d[4]) * (d[9] ? 1 : ev[6:4]));
			chk(core_eff_den_out, d[9] ? 1 : ev[3:1]);
			rd(1'b1, d & `CLK_MASK);
			rd_stop;
		end
		lay_e = 32'h08a2_000c;
		clk_e = d & `CLK_MASK;
		i_ldr.finish(1'b1);
		for (k = 0; k < 5 && cfg_locked_out !== 1'b1; k = k + 1)
			tick;
		chk({mem_if_rst_out, cfg_locked_out}, 32'h1);
		// Late load and writes with random byte enables change nothing
		i_ldr.load(1'b0, 32'h0, 1'b0, 1);
		for (i = 0; i < 2; i = i + 1) begin
			seed = xs(seed);
			mmio_wr_in = 1'b1;
			mmio_sel_in = i[0];
			mmio_be_in = seed[3:0];
			mmio_wdata_in = seed;
			tick;
			chk(mmio_wr_dropped_out, 32'h1);
			mmio_wr_in = 1'b0;
			tick;
		end
		tick;
		chk(refresh_interval_out, 32'h08a2);
		rd(1'b0, lay_e);
		rd(1'b1, clk_e);
		rd(1'b0, lay_e);
		rd_stop;
		// Second reset restores defaults and unlocks
		rst_n_in = 1'b0;
		i_ldr.finish(1'b0);
		tick;
		tick;
		rst_n_in = 1'b1;
		tick;
		check_defaults;
		for (k = 0; k < 10 && exp_q.size() > 0; k = k + 1)
			tick;
		chk(exp_q.size(), 32'h0);
		summarize;
	end
endmodule // mem_clk_cfg_regs_tb_top
